// *** hstr_cfg.svh ***
// Purpose: constants for the hub speed and traffic routing block
// Assumes: 100 MHz clock
// Notes:   timing counts derive from times in their own units
`ifndef HSTR_CFG_SVH
`define HSTR_CFG_SVH
`define HSTR_CLK_MHZ        100
`define HSTR_FRAME_US       1000
`define HSTR_UFRAME_NS      125000
`define HSTR_FRAME_CYC      ((`HSTR_FRAME_US * `HSTR_CLK_MHZ))
`define HSTR_UFRAME_CYC     ((`HSTR_UFRAME_NS * `HSTR_CLK_MHZ) / 1000)
`define HSTR_RESUME_US      20
`define HSTR_RESUME_CYC     ((`HSTR_RESUME_US * `HSTR_CLK_MHZ))
`define HSTR_NUM_PORTS      4
`define HSTR_FIFO_DEPTH     8
`define HSTR_DATA_W         8
`endif

// *** hstr_pkg.sv ***
// Purpose: types for the hub speed and traffic routing block
// Assumes: nothing
// Notes:   speed codes shared by ports and routing
package hstr_pkg;
    typedef enum logic [1:0] {
        HSTR_SPD_LOW,
        HSTR_SPD_FULL,
        HSTR_SPD_HIGH,
        HSTR_SPD_NONE
    } hstr_speed_t;
    typedef enum logic [1:0] {
        HSTR_RT_OFF,
        HSTR_RT_REPEATER,
        HSTR_RT_TRANSLATOR
    } hstr_route_t;
endpackage

// *** hstr_fifo.sv ***
// Purpose: shared translator buffer, valid/ready on both sides
// Assumes: single clock
// Notes:   depth must be a power of two
`timescale 1ns/10ps
module hstr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    input  wire logic [WIDTH-1:0] wr_data_in,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in,
    output logic      [WIDTH-1:0] rd_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      rp_q;
    logic             push;
    logic             pop;
    logic             full;
    logic             empty;

    assign full         = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty        = (wp_q == rp_q);
    assign wr_ready_out = !full;
    assign rd_valid_out = !empty;
    assign rd_data_out  = mem_q[rp_q[AW-1:0]];
    assign push         = wr_valid_in && !full;
    assign pop          = rd_ready_in && !empty;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop) rp_q <= rp_q + 1'b1;
        end
    end

    a_fifo_no_overflow: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        full && !pop |=> $stable(wp_q)) else $error("fifo written while full");
endmodule // hstr_fifo

// *** hstr_router.sv ***
// Purpose: upstream speed select, per-port routing, frame timer, resume, attach pull-up
// Assumes: inputs synchronous to clk_in; speeds come from the port detectors
// Notes:   one shared translator buffer serves every downstream port
`timescale 1ns/10ps
`include "hstr_cfg.svh"
module hstr_router #(
    parameter int NPORT     = `HSTR_NUM_PORTS,
    parameter int DW        = `HSTR_DATA_W,
    parameter int FDEPTH    = `HSTR_FIFO_DEPTH,
    parameter int FRAME_CYC = `HSTR_FRAME_CYC,
    parameter int UFRM_CYC  = `HSTR_UFRAME_CYC,
    parameter int RSM_CYC   = `HSTR_RESUME_CYC
) (
    input  wire logic               clk_in,
    input  wire logic               sys_rst_in,
    input  wire logic               host_hs_in,
    input  wire logic               speed_valid_in,
    input  wire logic               vbus_in,
    input  wire logic               sof_in,
    input  wire logic               suspend_in,
    input  wire logic               wakeup_in,
    input  wire logic [NPORT-1:0]   port_conn_in,
    input  wire logic [2*NPORT-1:0] port_speed_in,
    input  wire logic               tt_valid_in,
    output logic                    tt_ready_out,
    input  wire logic [DW-1:0]      tt_data_in,
    input  wire logic               tt_drain_in,
    output logic                    tt_valid_out,
    output logic [DW-1:0]           tt_data_out,
    output logic                    upstream_hs_out,
    output logic                    pullup_en_out,
    output logic [2*NPORT-1:0]      route_out,
    output logic                    sof_tick_out,
    output logic                    resume_out
);
    localparam int TW = $clog2(FRAME_CYC + 1);
    localparam int RW = $clog2(RSM_CYC + 1);

    logic              hs_q;
    logic              pullup_q;
    logic [TW-1:0]     tmr_q;
    logic [TW-1:0]     period_q;
    logic              tick_q;
    logic [RW-1:0]     rsm_q;
    logic              resume_q;
    logic [2*NPORT-1:0] route_q;
    logic [NPORT-1:0]  conn_q;
    logic              f_ready;
    logic              f_valid;
    logic [DW-1:0]     f_data;
    logic              tt_vq;
    logic [DW-1:0]     tt_dq;

    // speed is latched only when detected, so attach to a 1.1 host stays full speed
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hs_q <= 1'b0;
        end else if (!vbus_in) begin
            hs_q <= 1'b0;
        end else if (speed_valid_in) begin
            hs_q <= host_hs_in;
        end
    end

    // pull-up only while out of reset and bus power present
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pullup_q <= 1'b0;
        end else begin
            pullup_q <= vbus_in;
        end
    end

    // period learned from SOF spacing; the first SOF after reset already loads the timer count
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tmr_q    <= '0;
            period_q <= TW'(FRAME_CYC);
            tick_q   <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (sof_in) begin
                if (tmr_q != '0) period_q <= tmr_q + 1'b1;
                tmr_q <= '0;
                tick_q <= 1'b1;
            end else if (tmr_q + 1'b1 >= period_q) begin
                tmr_q  <= '0;
                tick_q <= 1'b1;
            end else begin
                tmr_q <= tmr_q + 1'b1;
            end
            if (!hs_q && period_q < TW'(UFRM_CYC)) period_q <= TW'(FRAME_CYC);
        end
    end

    // resume held for a fixed width so the repeater sees it across a slow clock
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rsm_q    <= '0;
            resume_q <= 1'b0;
        end else if (suspend_in && wakeup_in) begin
            rsm_q    <= RW'(RSM_CYC - 1);
            resume_q <= 1'b1;
        end else if (rsm_q != '0) begin
            rsm_q <= rsm_q - 1'b1;
        end else begin
            resume_q <= 1'b0;
        end
    end

    // routing reevaluated every cycle; connect/disconnect changes take effect next edge
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            route_q <= '0;
            conn_q  <= '0;
        end else begin
            conn_q <= port_conn_in;
            for (int i = 0; i < NPORT; i++) begin
                if (!port_conn_in[i]) begin
                    route_q[2*i +: 2] <= hstr_pkg::HSTR_RT_OFF;
                end else if (!hs_q) begin
                    route_q[2*i +: 2] <= hstr_pkg::HSTR_RT_REPEATER;
                end else if (port_speed_in[2*i +: 2] == hstr_pkg::HSTR_SPD_HIGH) begin
                    route_q[2*i +: 2] <= hstr_pkg::HSTR_RT_REPEATER;
                end else begin
                    route_q[2*i +: 2] <= hstr_pkg::HSTR_RT_TRANSLATOR;
                end
            end
        end
    end

    // single shared translator buffer; accepted only in high-speed mode
    hstr_fifo #(
        .WIDTH (DW),
        .DEPTH (FDEPTH)
    ) u_tt_buf (
        .clk_in       (clk_in),
        .sys_rst_in   (sys_rst_in),
        .wr_valid_in  (tt_valid_in && hs_q),
        .wr_ready_out (f_ready),
        .wr_data_in   (tt_data_in),
        .rd_valid_out (f_valid),
        .rd_ready_in  (tt_drain_in && !tt_vq),
        .rd_data_out  (f_data)
    );

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tt_vq <= 1'b0;
            tt_dq <= '0;
        end else begin
            tt_vq <= f_valid && tt_drain_in && !tt_vq;
            if (f_valid && tt_drain_in && !tt_vq) tt_dq <= f_data;
        end
    end

    assign upstream_hs_out = hs_q;
    assign pullup_en_out   = pullup_q;
    assign route_out       = route_q;
    assign sof_tick_out    = tick_q;
    assign resume_out      = resume_q;
    assign tt_valid_out    = tt_vq;
    assign tt_data_out     = tt_dq;
    assign tt_ready_out    = f_ready && hs_q;

    // assertions watch port 0; every port runs the same loop body
    a_pullup_vbus: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !vbus_in |=> !pullup_en_out)
        else $error("pull-up on without vbus");
    a_pullup_follow: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        vbus_in |=> pullup_en_out)
        else $error("pull-up off with vbus");
    a_fs_no_tt: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !upstream_hs_out |-> !tt_ready_out)
        else $error("translator open at full speed");
    a_route_tt: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        hs_q && port_conn_in[0] && port_speed_in[1:0] != hstr_pkg::HSTR_SPD_HIGH
        ##0 $stable(hs_q)[*1] |=> route_out[1:0] == hstr_pkg::HSTR_RT_TRANSLATOR)
        else $error("slow port not on translator");
    a_route_rep: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        port_conn_in[0] && (!hs_q || port_speed_in[1:0] == hstr_pkg::HSTR_SPD_HIGH)
        |=> route_out[1:0] == hstr_pkg::HSTR_RT_REPEATER)
        else $error("not on repeater");
    a_route_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !port_conn_in[0] |=> route_out[1:0] == hstr_pkg::HSTR_RT_OFF)
        else $error("detached port routed");
    a_resume_raise: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        suspend_in && wakeup_in |=> resume_out [*2])
        else $error("no resume");
    a_resume_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !suspend_in && !resume_out |=> !resume_out)
        else $error("resume while awake");
    a_sof_tick: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        sof_in |=> sof_tick_out && tmr_q == '0)
        else $error("sof not resynced");
    // a rollover keeps the learned period, so frames stay aligned between SOFs
    a_frame_roll: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sof_in && tmr_q + 1'b1 >= period_q |=> sof_tick_out && tmr_q == '0)
        else $error("frame rollover missed");
    a_speed_latch: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        vbus_in && speed_valid_in |=> upstream_hs_out == $past(host_hs_in))
        else $error("upstream speed wrong");
    a_fs_default: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !vbus_in |=> !upstream_hs_out)
        else $error("hs without attach");
    a_tt_gap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        tt_valid_out |=> !tt_valid_out)
        else $error("translator words too close");
    a_reset_pullup: assert property (@(posedge clk_in)
        sys_rst_in |-> !pullup_en_out)
        else $error("pull-up on in reset");

    // covers for the main scenarios
    c_hs_attach: cover property (@(posedge clk_in) vbus_in && speed_valid_in && host_hs_in);
    c_tt_full: cover property (@(posedge clk_in) hs_q && !f_ready);
    c_resume: cover property (@(posedge clk_in) suspend_in && wakeup_in);
    c_sof_pair: cover property (@(posedge clk_in) sof_in ##[1:300] sof_in);
    c_port_attach: cover property (@(posedge clk_in) !conn_q[0] && port_conn_in[0]);
endmodule // hstr_router

// *** hstr_host_model.sv ***
// Purpose: upstream host model: chirp result, bus power, periodic SOF
// Assumes: driven from the clk_in domain
// Notes:   SOF stops when sof_en_in falls, as after a host halt
`timescale 1ns/10ps
module hstr_host_model #(
    parameter int SOF_PER = 20
) (
    input  wire logic clk_in,
    input  wire logic attach_in,
    input  wire logic hs_in,
    input  wire logic sof_en_in,
    output logic      vbus_out,
    output logic      host_hs_out,
    output logic      speed_valid_out,
    output logic      sof_out
);
    int cnt_q = 0;
    assign vbus_out        = attach_in;
    assign speed_valid_out = attach_in;
    // chirp result is meaningless while detached, so show the inverse
    assign host_hs_out     = attach_in ? hs_in : ~hs_in;
    always_ff @(posedge clk_in) begin
        // no SOF while the cable is out
        cnt_q   <= (!sof_en_in || !attach_in || cnt_q == SOF_PER - 1) ? 0 : cnt_q + 1;
        sof_out <= sof_en_in && attach_in && cnt_q == SOF_PER - 1;
    end
endmodule // hstr_host_model

// *** testbench.sv ***
// Purpose: self-checking bench for the hub routing block
// Assumes: short frame, microframe and resume counts
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/10ps
module testbench;
    localparam int SOF_P = 20;
    localparam int RSM   = 4;
    // reset rises in the initial block so the asynchronous reset sees an edge at time 0
    logic clk_in = 1'b0, sys_rst_in, attach = 1'b0, hs = 1'b0, sof_en = 1'b1;
    logic suspend_in = 1'b0, wakeup_in = 1'b0, tt_valid_in = 1'b0, tt_drain_in = 1'b0;
    logic [3:0] port_conn_in = 4'h0;
    logic [7:0] port_speed_in = 8'hFF, tt_data_in = 8'h00, tt_data_out, route_out;
    logic vbus, host_hs, speed_valid, sof, tt_ready_out, tt_valid_out;
    logic upstream_hs_out, pullup_en_out, sof_tick_out, resume_out;
    int   err_total = 0, total_checks = 0;
    always #5 clk_in = ~clk_in;
    hstr_host_model #(.SOF_PER(SOF_P)) i_hstr_host_model (.clk_in(clk_in),
        .attach_in(attach), .hs_in(hs), .sof_en_in(sof_en), .vbus_out(vbus),
        .host_hs_out(host_hs), .speed_valid_out(speed_valid), .sof_out(sof));
    hstr_router #(.FRAME_CYC(64), .UFRM_CYC(8), .RSM_CYC(RSM)) i_hstr_router (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .host_hs_in(host_hs),
        .speed_valid_in(speed_valid), .vbus_in(vbus), .sof_in(sof),
        .suspend_in(suspend_in), .wakeup_in(wakeup_in), .port_conn_in(port_conn_in),
        .port_speed_in(port_speed_in), .tt_valid_in(tt_valid_in),
        .tt_ready_out(tt_ready_out), .tt_data_in(tt_data_in), .tt_drain_in(tt_drain_in),
        .tt_valid_out(tt_valid_out), .tt_data_out(tt_data_out),
        .upstream_hs_out(upstream_hs_out), .pullup_en_out(pullup_en_out),
        .route_out(route_out), .sof_tick_out(sof_tick_out), .resume_out(resume_out));
    task automatic tick(int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic t_full;
        attach = 1'b1;
        hs = 1'b0;
        port_conn_in = 4'h7;
        port_speed_in = {hstr_pkg::HSTR_SPD_FULL, hstr_pkg::HSTR_SPD_FULL,
                         hstr_pkg::HSTR_SPD_LOW, hstr_pkg::HSTR_SPD_FULL};
        tick(3);
        chk("upstream hs", upstream_hs_out, 0);
        chk("pullup", pullup_en_out, 1);
        chk("route fs", route_out, 8'h15);
        chk("tt ready fs", tt_ready_out, 0);
        $display("t_full done");
    endtask
    task automatic t_high;
        hs = 1'b1;
        port_speed_in = {hstr_pkg::HSTR_SPD_HIGH, hstr_pkg::HSTR_SPD_HIGH,
                         hstr_pkg::HSTR_SPD_FULL, hstr_pkg::HSTR_SPD_LOW};
        tick(3);
        chk("upstream hs", upstream_hs_out, 1);
        chk("route hs", route_out, 8'h1A);
        port_conn_in = 4'hF;
        tick(2);
        chk("route attach", route_out, 8'h5A);
        port_conn_in = 4'hE;
        tick(2);
        chk("route detach", route_out, 8'h58);
        $display("t_high done");
    endtask
    task automatic t_fifo;
        int k, n;
        for (int i = 0; i < 9; i++) begin
            tt_valid_in = 1'b1;
            tt_data_in = 8'hA0 + 8'(i);
            #1;
            chk("tt ready", tt_ready_out, i < 8);
            tick(1);
        end
        tt_valid_in = 1'b0;
        tt_drain_in = 1'b1;
        k = 0;
        n = 0;
        while (k < 8 && n < 60) begin
            tick(1);
            n++;
            if (tt_valid_out === 1'b1) begin
                chk("tt data", tt_data_out, 8'hA0 + 8'(k));
                k++;
            end
        end
        chk("tt count", 8'(k), 8);
        tick(6);
        chk("tt empty", tt_valid_out, 0);
        $display("t_fifo done");
    endtask
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            tick(1);
            n++;
        end while (sof_tick_out !== 1'b1 && n < 200);
    endtask
    task automatic t_frame;
        int n;
        tick(3 * SOF_P);
        sof_en = 1'b0;
        wait_tick(n);
        wait_tick(n);
        chk("frame gap", 8'(n), 8'(SOF_P));
        $display("t_frame done");
    endtask
    task automatic t_resume;
        int n;
        wakeup_in = 1'b1;
        tick(2);
        chk("resume idle", resume_out, 0);
        suspend_in = 1'b1;
        tick(1);
        wakeup_in = 1'b0;
        n = 0;
        while (resume_out !== 1'b1 && n < 5) begin
            tick(1);
            n++;
        end
        n = 0;
        while (resume_out === 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk("resume length", 8'(n), 8'(RSM));
        suspend_in = 1'b0;
        $display("t_resume done");
    endtask
    task automatic t_vbus_rst;
        sys_rst_in = 1'b1;
        tick(1);
        chk("rst pullup", pullup_en_out, 0);
        chk("rst route", route_out, 0);
        chk("rst hs", upstream_hs_out, 0);
        sys_rst_in = 1'b0;
        tick(3);
        chk("route again", route_out, 8'h58);
        attach = 1'b0;
        tick(2);
        chk("no vbus pullup", pullup_en_out, 0);
        $display("t_vbus_rst done");
    endtask
    initial begin
        sys_rst_in = 1'b1;
        tick(2);
        chk("reset pullup", pullup_en_out, 0);
        chk("reset route", route_out, 0);
        sys_rst_in = 1'b0;
        t_full();
        t_high();
        t_fifo();
        t_frame();
        t_resume();
        t_vbus_rst();
        results();
    end
    initial begin
        #100000;
        err_total++;
        results();
    end
endmodule // testbench
